// *** fasp_pkg.sv ***
// Package for the FIFO asynchronous serial port: register map, field layout, reset values and timing.
// Assumes a 125 MHz system clock and a 32-bit Avalon-MM slave whose address carries the byte offsets directly.
package fasp_pkg;
   // Register byte offsets.
   localparam logic [3:0] OFF_FORMAT = 4'h0;
   localparam logic [3:0] OFF_DIVISOR = 4'h4;
   localparam logic [3:0] OFF_CONTROL = 4'h8;
   localparam logic [3:0] OFF_STATUS = 4'hC;
   // Data queue offsets share the upper half of the window.
   localparam logic [4:0] OFF_TXDATA = 5'h10;
   localparam logic [4:0] OFF_RXDATA = 5'h14;
   localparam logic [4:0] OFF_LEVELS = 5'h18;
   localparam int ADDR_W = 5;
   // Format register fields.
   localparam int FMT_CHR = 6;
   localparam int FMT_PAR_ON = 5;
   localparam int FMT_ODD = 4;
   localparam int FMT_STOP2 = 3;
   localparam logic [7:0] FMT_WMASK = 8'h7B;
   localparam logic [7:0] FORMAT_RST = 8'h00;
   // Control register fields.
   localparam int CTL_TX_EN = 5;
   localparam int CTL_RX_EN = 4;
   localparam int CTL_MODEM = 3;
   localparam int CTL_CLK_EXT = 1;
   localparam int CTL_CLK_OUT = 0;
   localparam logic [7:0] CTL_WMASK = 8'h3B;
   localparam logic [7:0] CONTROL_RST = 8'h00;
   localparam logic [7:0] DIVISOR_RST = 8'hFF;
   // Status register bit positions; the error, break and timeout flags clear by writing 1.
   localparam int ST_ERR = 7;
   localparam int ST_TEND = 6;
   localparam int ST_TXEMPTY = 5;
   localparam int ST_BRK = 4;
   localparam int ST_RXFULL = 1;
   localparam int ST_TIMEOUT = 0;
   // Queue geometry.
   localparam int DEPTH = 16;
   localparam int PTR_W = 4;
   localparam logic [PTR_W:0] DEPTH_CNT = 5'h10;
   // Oversampling: sixteen ticks per bit, sample at the middle tick.
   localparam logic [3:0] OVS_LAST = 4'hF;
   localparam logic [3:0] OVS_MID = 4'h7;
   // Receive timeout in bit times of idle line (about 1.5 chars of 10 bits).
   localparam logic [7:0] TIMEOUT_BITS = 8'h0F;
   localparam logic [5:0] PRESCALE_4 = 6'h03;
   localparam logic [5:0] PRESCALE_16 = 6'h0F;
   localparam logic [5:0] PRESCALE_64 = 6'h3F;
   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} fasp_tx_e;
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} fasp_rx_e;
endpackage

// *** fasp_top.sv ***
// FIFO asynchronous serial port: Avalon-MM registers, baud generator, transmitter and receiver.
// Assumes serial pins already synchronous to clk_sys and a single-word bus master.
// Contract
// (RQ1) Receiver shifts bits LSB first into queue.
// (RQ2) Receive queue holds sixteen bytes.
// (RQ3) Byte arriving at full queue is dropped.
// (RQ4) Receive queue read only; empty read undefined.
// (RQ5) Transmitter drains queue LSB first until empty.
// (RQ6) Transmit queue sixteen bytes; full writes ignored.
// (RQ7) Format bit 6 selects seven data bits.
// (RQ8) Format bit 5 enables parity add and check.
// (RQ9) Format bit 4 odd parity, ignored without parity.
// (RQ10) Parity makes ones count even or odd.
// (RQ11) Format bit 3 selects two stop bits.
// (RQ12) Receiver checks only the first stop bit.
// (RQ13) Format bits 7 and 2 read zero.
// (RQ14) Format bits 1:0 pick prescale 1,4,16,64.
// (RQ15) Bit clock internal or from clock pin.
// (RQ16) Transmit and receive run independently, full duplex.
// (RQ17) Four independent request outputs raised.
// (RQ18) Empty and full requests also drive DMA.
// (RQ19) Receive timeout detected, reported by flag.
// (RQ20) Queue levels and error count readable.
// (RQ21) Clock pin carries sixteen times bit rate.
// (RQ22) Stop or parity error flags, byte kept.
// (RQ23) Send request shows space; permit gates transmit.
//
// The implementer's own choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module fasp_top (
   // System.
   input wire logic clk_sys,
   input wire logic rst,
   // Avalon-MM slave.
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Serial pins.
   input wire logic serial_in_pin,
   output logic serial_out_pin,
   input wire logic link_clock_pin_in,
   output logic link_clock_pin_out,
   output logic link_clock_pin_oe,
   output logic send_request_out,
   input wire logic send_permit_in,
   // Requests to processor and transfer engine.
   output logic req_tx_empty,
   output logic req_break,
   output logic req_rx_full,
   output logic req_rx_error,
   output logic transfer_engine_tx_req,
   output logic transfer_engine_rx_req
);
   logic [7:0] frame_format_reg;
   logic [7:0] divisor;
   logic [7:0] control;
   wire logic ack = ~avs_waitrequest;
   // Bus decode; every access answers one cycle after it is seen.
   wire logic req = (avs_read | avs_write) & ~ack;
   wire logic wr = avs_write & ack;
   wire logic rd = avs_read & ~ack;
   wire logic sel_fmt = avs_address == {1'b0, fasp_pkg::OFF_FORMAT};
   wire logic sel_div = avs_address == {1'b0, fasp_pkg::OFF_DIVISOR};
   wire logic sel_ctl = avs_address == {1'b0, fasp_pkg::OFF_CONTROL};
   wire logic sel_st = avs_address == {1'b0, fasp_pkg::OFF_STATUS};
   wire logic sel_txd = avs_address == fasp_pkg::OFF_TXDATA;
   wire logic sel_rxd = avs_address == fasp_pkg::OFF_RXDATA;
   wire logic sel_lvl = avs_address == fasp_pkg::OFF_LEVELS;
   wire logic [7:0] wd = avs_writedata[7:0];
   // Software-facing registers.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         frame_format_reg <= fasp_pkg::FORMAT_RST;
         divisor <= fasp_pkg::DIVISOR_RST;
         control <= fasp_pkg::CONTROL_RST;
      end else if (wr) begin
         if (sel_fmt) frame_format_reg <= wd & fasp_pkg::FMT_WMASK; // RQ13
         if (sel_div) divisor <= wd;
         if (sel_ctl) control <= wd & fasp_pkg::CTL_WMASK;
      end
   end
   // Prescaler then divisor make a sixteen-times-bit-rate tick.
   logic [5:0] pre_cnt;
   logic [7:0] div_cnt;
   logic ovs_int;
   logic clkin_d;
   logic clk_out;
   wire logic [5:0] pre_top = frame_format_reg[1:0] == 2'h0 ? 6'h00 :
                              frame_format_reg[1:0] == 2'h1 ? fasp_pkg::PRESCALE_4 :
                              frame_format_reg[1:0] == 2'h2 ? fasp_pkg::PRESCALE_16 : fasp_pkg::PRESCALE_64; // RQ14
   wire logic pre_tick = pre_cnt >= pre_top;
   // A zero divisor cannot make a clock at any prescale, so the pin then stays high.
   wire logic clk_hi = div_cnt <= {1'b0, divisor[7:1]};
   wire logic ext_clk = control[fasp_pkg::CTL_CLK_EXT];
   wire logic ovs = ext_clk ? (link_clock_pin_in & ~clkin_d) : ovs_int; // RQ15 RQ21
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pre_cnt <= 6'h00;
         div_cnt <= 8'h00;
         ovs_int <= 1'b0;
         clkin_d <= 1'b0;
         clk_out <= 1'b0;
      end else begin
         clkin_d <= link_clock_pin_in;
         clk_out <= clk_hi; // RQ21
         pre_cnt <= pre_tick ? 6'h00 : pre_cnt + 6'h01;
         ovs_int <= 1'b0;
         if (pre_tick) begin
            if (div_cnt >= divisor) begin
               div_cnt <= 8'h00;
               ovs_int <= 1'b1;
            end else begin
               div_cnt <= div_cnt + 8'h01;
            end
         end
      end
   end
   // Transmit queue storage and pointers.
   logic [7:0] txq [fasp_pkg::DEPTH];
   logic [fasp_pkg::PTR_W-1:0] txw, txr;
   logic [fasp_pkg::PTR_W:0] txn;
   wire logic tx_full = txn == fasp_pkg::DEPTH_CNT;
   wire logic tx_push = wr & sel_txd & ~tx_full; // RQ6
   logic tx_pop;
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         txw <= '0;
         txr <= '0;
         txn <= '0;
      end else begin
         if (tx_push) begin
            txq[txw] <= wd;
            txw <= txw + 4'h1;
         end
         if (tx_pop) txr <= txr + 4'h1;
         txn <= txn + {4'h0, tx_push} - {4'h0, tx_pop};
      end
   end
   // Transmitter: loads the next byte when its shifter is free, LSB first.
   fasp_pkg::fasp_tx_e tx_st;
   logic [7:0] tx_shifter;
   logic [3:0] tx_ovs;
   logic [2:0] tx_bit;
   logic tx_par;
   logic tx_line;
   logic tend;
   wire logic tx_bit_end = ovs & (tx_ovs == fasp_pkg::OVS_LAST);
   wire logic [2:0] last_bit = frame_format_reg[fasp_pkg::FMT_CHR] ? 3'h6 : 3'h7; // RQ7
   wire logic permit = ~control[fasp_pkg::CTL_MODEM] | ~send_permit_in; // RQ23
   assign tx_pop = (tx_st == fasp_pkg::TX_IDLE) & (txn != '0) & control[fasp_pkg::CTL_TX_EN] & permit; // RQ5
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         tx_st <= fasp_pkg::TX_IDLE;
         tx_shifter <= 8'h00;
         tx_ovs <= 4'h0;
         tx_bit <= 3'h0;
         tx_par <= 1'b0;
         tx_line <= 1'b1;
         tend <= 1'b1;
      end else begin
         if (ovs) tx_ovs <= tx_ovs + 4'h1;
         unique case (tx_st)
            fasp_pkg::TX_IDLE: begin
               tx_line <= 1'b1;
               if (tx_pop) begin
                  tx_shifter <= txq[txr];
                  tx_par <= frame_format_reg[fasp_pkg::FMT_ODD]; // RQ9
                  tx_ovs <= 4'h0;
                  tend <= 1'b0;
                  tx_line <= 1'b0;
                  tx_st <= fasp_pkg::TX_START;
               end
            end
            fasp_pkg::TX_START: if (tx_bit_end) begin
               tx_line <= tx_shifter[0]; // RQ5
               tx_bit <= 3'h0;
               tx_st <= fasp_pkg::TX_DATA;
            end
            fasp_pkg::TX_DATA: if (tx_bit_end) begin
               tx_par <= tx_par ^ tx_shifter[0]; // RQ10
               tx_shifter <= {1'b0, tx_shifter[7:1]};
               tx_bit <= tx_bit + 3'h1;
               if (tx_bit != last_bit) begin
                  tx_line <= tx_shifter[1];
               end else if (frame_format_reg[fasp_pkg::FMT_PAR_ON]) begin // RQ8
                  tx_line <= tx_par ^ tx_shifter[0];
                  tx_st <= fasp_pkg::TX_PAR;
               end else begin
                  tx_line <= 1'b1;
                  tx_bit <= 3'h0;
                  tx_st <= fasp_pkg::TX_STOP;
               end
            end
            fasp_pkg::TX_PAR: if (tx_bit_end) begin
               tx_line <= 1'b1;
               tx_bit <= 3'h0;
               tx_st <= fasp_pkg::TX_STOP;
            end
            fasp_pkg::TX_STOP: if (tx_bit_end) begin
               if (frame_format_reg[fasp_pkg::FMT_STOP2] && tx_bit == 3'h0) begin // RQ11
                  tx_bit <= 3'h1;
               end else begin
                  tend <= txn == '0;
                  tx_st <= fasp_pkg::TX_IDLE;
               end
            end
         endcase
      end
   end
   // Receive queue with per-entry error marks for counting.
   logic [7:0] rxq [fasp_pkg::DEPTH];
   logic [fasp_pkg::DEPTH-1:0] rxq_err;
   logic [fasp_pkg::PTR_W-1:0] rxw, rxr;
   logic [fasp_pkg::PTR_W:0] rxn, errn;
   logic rx_done, rx_bad;
   logic [7:0] rx_shifter;
   wire logic rx_full = rxn == fasp_pkg::DEPTH_CNT; // RQ2
   wire logic rx_push = rx_done & ~rx_full; // RQ3
   wire logic rx_pop = rd & sel_rxd & (rxn != '0); // RQ4
   wire logic pop_err = rx_pop & rxq_err[rxr];
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rxw <= '0;
         rxr <= '0;
         rxn <= '0;
         errn <= '0;
         rxq_err <= '0;
      end else begin
         if (rx_push) begin
            rxq[rxw] <= rx_shifter; // RQ1
            rxq_err[rxw] <= rx_bad; // RQ22
            rxw <= rxw + 4'h1;
         end
         if (rx_pop) rxr <= rxr + 4'h1;
         rxn <= rxn + {4'h0, rx_push} - {4'h0, rx_pop};
         errn <= errn + {4'h0, rx_push & rx_bad} - {4'h0, pop_err}; // RQ20
      end
   end
   // Receiver: start on a low line level in idle, sample mid-bit, check first stop only.
   fasp_pkg::fasp_rx_e rx_st;
   logic [3:0] rx_ovs;
   logic [2:0] rx_bit;
   logic rx_par;
   logic rx_allzero;
   logic [7:0] idle_bits;
   wire logic rx_mid = ovs & (rx_ovs == fasp_pkg::OVS_MID);
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rx_st <= fasp_pkg::RX_IDLE;
         rx_ovs <= 4'h0;
         rx_bit <= 3'h0;
         rx_par <= 1'b0;
         rx_shifter <= 8'h00;
         rx_done <= 1'b0;
         rx_bad <= 1'b0;
         rx_allzero <= 1'b0;
      end else begin
         rx_done <= 1'b0;
         if (ovs) rx_ovs <= rx_ovs + 4'h1;
         unique case (rx_st)
            fasp_pkg::RX_IDLE: if (control[fasp_pkg::CTL_RX_EN] && !serial_in_pin) begin
               rx_ovs <= 4'h0;
               rx_st <= fasp_pkg::RX_START;
            end
            fasp_pkg::RX_START: if (rx_mid) begin
               rx_st <= serial_in_pin ? fasp_pkg::RX_IDLE : fasp_pkg::RX_DATA;
               rx_bit <= 3'h0;
               rx_shifter <= 8'h00;
               rx_par <= frame_format_reg[fasp_pkg::FMT_ODD]; // RQ9
               rx_allzero <= 1'b1;
            end
            fasp_pkg::RX_DATA: if (rx_mid) begin
               rx_shifter[rx_bit] <= serial_in_pin; // RQ1
               rx_par <= rx_par ^ serial_in_pin;
               rx_allzero <= rx_allzero & ~serial_in_pin;
               rx_bit <= rx_bit + 3'h1;
               if (rx_bit == last_bit) begin
                  rx_st <= frame_format_reg[fasp_pkg::FMT_PAR_ON] ? fasp_pkg::RX_PAR : fasp_pkg::RX_STOP;
               end
            end
            fasp_pkg::RX_PAR: if (rx_mid) begin
               rx_par <= rx_par ^ serial_in_pin; // RQ10
               rx_allzero <= rx_allzero & ~serial_in_pin;
               rx_st <= fasp_pkg::RX_STOP;
            end
            fasp_pkg::RX_STOP: if (rx_mid) begin
               // A second stop bit is not examined; a low there starts the next frame.
               rx_bad <= ~serial_in_pin | (frame_format_reg[fasp_pkg::FMT_PAR_ON] & rx_par); // RQ12 RQ22
               rx_allzero <= rx_allzero & ~serial_in_pin;
               rx_done <= 1'b1;
               rx_st <= fasp_pkg::RX_IDLE;
            end
         endcase
      end
   end
   // Sticky status flags; hardware set wins over a software clear.
   logic err_f, brk_f, tmo_f;
   wire logic clr = wr & sel_st;
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         err_f <= 1'b0;
         brk_f <= 1'b0;
         tmo_f <= 1'b0;
         idle_bits <= 8'h00;
      end else begin
         err_f <= (rx_done & rx_bad) | (err_f & ~(clr & wd[fasp_pkg::ST_ERR])); // RQ22
         brk_f <= (rx_done & rx_allzero) | (brk_f & ~(clr & wd[fasp_pkg::ST_BRK])); // RQ17
         if (rx_push || rx_pop || rxn == '0) begin
            idle_bits <= 8'h00;
         end else if (rx_mid && rx_st == fasp_pkg::RX_IDLE && idle_bits != fasp_pkg::TIMEOUT_BITS) begin
            idle_bits <= idle_bits + 8'h01;
         end
         tmo_f <= (rx_mid && idle_bits == fasp_pkg::TIMEOUT_BITS - 8'h01) |
                  (tmo_f & ~(clr & wd[fasp_pkg::ST_TIMEOUT])); // RQ19
      end
   end
   // Readback mux; reserved bits read zero.
   wire logic [7:0] status = {err_f, tend, txn == '0, brk_f, 2'b00, rx_full, tmo_f};
   wire logic [31:0] rdata = sel_fmt ? {24'h0, frame_format_reg} :
                             sel_div ? {24'h0, divisor} :
                             sel_ctl ? {24'h0, control} :
                             sel_st ? {16'h0, 3'h0, errn, status} :
                             sel_rxd ? {24'h0, rxq[rxr]} :
                             sel_lvl ? {16'h0, 3'h0, txn, 3'h0, rxn} : 32'h0; // RQ20
   // Outputs all leave from flip-flops.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0;
         serial_out_pin <= 1'b1;
         link_clock_pin_out <= 1'b0;
         link_clock_pin_oe <= 1'b0;
         send_request_out <= 1'b1;
         req_tx_empty <= 1'b0;
         req_break <= 1'b0;
         req_rx_full <= 1'b0;
         req_rx_error <= 1'b0;
         transfer_engine_tx_req <= 1'b0;
         transfer_engine_rx_req <= 1'b0;
      end else begin
         avs_waitrequest <= ~req;
         if (rd) avs_readdata <= rdata;
         serial_out_pin <= tx_line;
         link_clock_pin_out <= clk_out;
         link_clock_pin_oe <= ~ext_clk & control[fasp_pkg::CTL_CLK_OUT]; // RQ21
         send_request_out <= control[fasp_pkg::CTL_MODEM] & rx_full; // RQ23
         req_tx_empty <= control[fasp_pkg::CTL_TX_EN] & (txn == '0); // RQ16 RQ17
         req_break <= brk_f;
         req_rx_full <= rx_full;
         req_rx_error <= err_f;
         transfer_engine_tx_req <= control[fasp_pkg::CTL_TX_EN] & (txn == '0); // RQ18
         transfer_engine_rx_req <= rx_full;
      end
   end
   // Assertions.
   a_tx_queue_bound: assert property (@(posedge clk_sys) disable iff (rst) txn <= fasp_pkg::DEPTH_CNT) // RQ6
      else $error("transmit queue over depth");
   a_rx_drop_full: assert property (@(posedge clk_sys) disable iff (rst)
      rx_done && rx_full && !rx_pop |=> rxn == fasp_pkg::DEPTH_CNT) // RQ3
      else $error("receive byte stored into full queue");
   a_err_sets_flag: assert property (@(posedge clk_sys) disable iff (rst)
      rx_done && rx_bad |=> err_f) // RQ22
      else $error("receive error flag not set");
   a_idle_line_high: assert property (@(posedge clk_sys) disable iff (rst)
      tx_st == fasp_pkg::TX_IDLE && !tx_pop |=> tx_line) // RQ5
      else $error("line not idle high");
   a_fmt_reserved: assert property (@(posedge clk_sys) disable iff (rst)
      frame_format_reg[7] == 1'b0 && frame_format_reg[2] == 1'b0) // RQ13
      else $error("reserved format bits set");
   a_bus_answer: assert property (@(posedge clk_sys) disable iff (rst)
      req |=> !avs_waitrequest) // RQ4
      else $error("bus answer late");
   a_err_count: assert property (@(posedge clk_sys) disable iff (rst) errn <= rxn) // RQ20
      else $error("error count exceeds level");
   a_permit_gate: assert property (@(posedge clk_sys) disable iff (rst)
      control[fasp_pkg::CTL_MODEM] && send_permit_in && tx_st == fasp_pkg::TX_IDLE
      |=> tx_st == fasp_pkg::TX_IDLE) // RQ23
      else $error("transmit started without permit");
   c_tx_frame: cover property (@(posedge clk_sys) tx_pop);
   c_rx_push: cover property (@(posedge clk_sys) rx_push);
   c_rx_error: cover property (@(posedge clk_sys) rx_done && rx_bad);
   c_timeout: cover property (@(posedge clk_sys) tmo_f);
endmodule // fasp_top
`default_nettype wire

// *** fasp_remote.sv ***
// Remote serial party: sends frames into the port and captures the frames that the port sends.
// Assumes a free-running system clock; bit times are counted in its cycles.
`timescale 1ns/1ns
`default_nettype none
module fasp_remote (
   // Clock.
   input wire logic clk_sys,
   // Serial line pair seen from the remote side.
   input wire logic line_in,
   output logic line_out
);
   // The line rests at the mark level between frames.
   initial line_out = 1'b1;

   // Drives one bit for a sixteen-cycle bit time.
   task automatic put(input logic b);
      @(posedge clk_sys);
      line_out <= b;
      repeat (15) @(posedge clk_sys);
   endtask

   // Sends one frame; pf is parity on, odd, flipped; bs spoils the stop bit.
   // Good frames follow each other with no idle gap, so a second stop is never implied.
   task automatic send(input logic [7:0] d, input logic [2:0] pf, input logic bs);
      put(1'b0);
      for (int i = 0; i < 8; i++) put(d[i]);
      if (pf[0]) put(^d ^ pf[1] ^ pf[2]);
      put(~bs);
      if (bs) put(1'b1);
   endtask

   // Captures data, parity and stop bits of one frame, lowest first, at mid-bit.
   task automatic recv(output logic [10:0] r, input logic [7:0] f, input int bc);
      int n;
      int m;
      r = 'x;
      n = 0;
      m = 9 + f[5] + f[3] - f[6];
      while (line_in !== 1'b0 && n < 9000) begin
         @(posedge clk_sys);
         n++;
      end
      if (n < 9000) begin
         r = '0;
         repeat (bc / 2) @(posedge clk_sys);
         for (int i = 0; i < m; i++) begin
            repeat (bc) @(posedge clk_sys);
            r[i] = line_in;
         end
      end
   endtask
endmodule // fasp_remote
`default_nettype wire

// *** fasp_top_tb_top.sv ***
// Bench for the serial port: bus master tasks, the remote partner and hand-written scenarios.
// Assumes fasp_pkg, fasp_top and fasp_remote compile first; divisor 0 gives sixteen-cycle bits.
`timescale 1ns/1ns
`default_nettype none
module fasp_top_tb_top;
   localparam logic [4:0] A_FMT = {1'b0, fasp_pkg::OFF_FORMAT};
   localparam logic [4:0] A_DIV = {1'b0, fasp_pkg::OFF_DIVISOR};
   localparam logic [4:0] A_CTL = {1'b0, fasp_pkg::OFF_CONTROL};
   localparam logic [4:0] A_ST = {1'b0, fasp_pkg::OFF_STATUS};
   localparam logic [4:0] A_TX = fasp_pkg::OFF_TXDATA;
   localparam logic [4:0] A_RX = fasp_pkg::OFF_RXDATA;
   localparam logic [4:0] A_LV = fasp_pkg::OFF_LEVELS;
   logic clk_sys, rst, avs_read, avs_write, avs_waitrequest, serial_in_pin, serial_out_pin;
   logic link_clock_pin_out, link_clock_pin_oe, ext_clk, ext_run, send_request_out, send_permit_in;
   logic req_tx_empty, req_break, req_rx_full, req_rx_error, transfer_engine_tx_req, transfer_engine_rx_req;
   logic [4:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [10:0] r;
   wire logic link_wire;
   int err_total, n_checks;

   // The clock pin level follows whoever enables it; the remote drives it otherwise.
   assign link_wire = link_clock_pin_oe ? link_clock_pin_out : ext_clk;

   fasp_top u_dut (.clk_sys, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
      .avs_waitrequest, .serial_in_pin, .serial_out_pin, .link_clock_pin_in(link_wire), .link_clock_pin_out,
      .link_clock_pin_oe, .send_request_out, .send_permit_in, .req_tx_empty, .req_break, .req_rx_full,
      .req_rx_error, .transfer_engine_tx_req, .transfer_engine_rx_req);
   fasp_remote u_rem (.clk_sys, .line_in(serial_out_pin), .line_out(serial_in_pin));

   // System clock with an 8 ns period.
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   // The remote clock runs only while a scenario needs it, rising every second cycle.
   always @(posedge clk_sys) begin
      ext_clk <= ext_run ? ~ext_clk : 1'b0;
   end

   // Compares one value and counts the result.
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
      end
   endtask

   // Prints the verdict and ends the run.
   task automatic summarize();
      if (err_total == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // One bus access, held until waitrequest is sampled low; a bounded wait guards a hang.
   task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d, output logic [31:0] q);
      int n;
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= {24'h000000, d};
      avs_write <= wr;
      avs_read <= ~wr;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 100);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (n >= 100) begin
         err_total++;
         summarize();
      end
   endtask

   // Register write and masked register read with comparison.
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rdc(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 8'h00, q);
      chk(q & m, e);
   endtask

   // Reset values, reserved format bits and an unmapped address; then a fast bit rate.
   task automatic t_regs();
      rdc(A_FMT, 32'hFF, 32'(fasp_pkg::FORMAT_RST));
      rdc(A_DIV, 32'hFF, 32'(fasp_pkg::DIVISOR_RST));
      rdc(A_CTL, 32'hFF, 32'(fasp_pkg::CONTROL_RST));
      rdc(5'h1C, 32'hFFFFFFFF, 32'h0);
      wr(A_FMT, 8'hFF);
      rdc(A_FMT, 32'hFF, 32'h7B);
      wr(A_FMT, 8'h00);
      wr(A_DIV, 8'h00);
      wr(A_CTL, 8'h30);
   endtask

   // Six frame formats in turn; expected bits are built from the format byte.
   task automatic t_tx_fmt();
      logic [7:0] fl [6] = '{8'h00, 8'h40, 8'h20, 8'h30, 8'h08, 8'h10};
      logic [10:0] e;
      int k;
      foreach (fl[j]) begin
         wr(A_FMT, fl[j]);
         wr(A_TX, 8'hB5);
         u_rem.recv(r, fl[j], 16);
         e = fl[j][6] ? 11'h035 : 11'h0B5;
         k = fl[j][6] ? 7 : 8;
         if (fl[j][5]) begin
            e[k] = ^e[7:0] ^ fl[j][4];
            k++;
         end
         e[k] = 1'b1;
         e[k + 1] = fl[j][3];
         chk({21'h0, r}, {21'h0, e});
         repeat (40) @(posedge clk_sys);
      end
   endtask

   // Seventeen writes with the sender off; sixteen come out back to back, the last one was dropped.
   task automatic t_tx_full();
      wr(A_CTL, 8'h10);
      for (int i = 0; i < 17; i++) wr(A_TX, 8'(i));
      rdc(A_LV, 32'h1F00, 32'h1000);
      wr(A_CTL, 8'h30);
      for (int i = 0; i < 16; i++) begin
         u_rem.recv(r, 8'h00, 16);
         chk({21'h0, r}, 32'h100 + i);
      end
      repeat (40) @(posedge clk_sys);
      chk({30'h0, req_tx_empty, transfer_engine_tx_req}, 32'h3);
   endtask

   // Full duplex exchange, then idle timeout, parity fault, stop fault and break.
   task automatic t_rx();
      logic [31:0] q;
      fork
         u_rem.recv(r, 8'h00, 16);
         u_rem.send(8'h3C, 3'b000, 1'b0);
         wr(A_TX, 8'h5A);
      join
      chk({21'h0, r}, 32'h15A);
      rdc(A_LV, 32'h1F, 32'h01);
      repeat (300) @(posedge clk_sys);
      rdc(A_ST, 32'h01, 32'h01);
      rdc(A_RX, 32'hFF, 32'h3C);
      wr(A_ST, 8'hFF);
      wr(A_FMT, 8'h20);
      u_rem.send(8'h96, 3'b101, 1'b0);
      rdc(A_ST, 32'h1F80, 32'h0180);
      chk({31'h0, req_rx_error}, 32'h1);
      rdc(A_RX, 32'hFF, 32'h96);
      rdc(A_ST, 32'h1F00, 32'h0);
      wr(A_ST, 8'hFF);
      wr(A_FMT, 8'h00);
      u_rem.send(8'h55, 3'b000, 1'b1);
      rdc(A_ST, 32'h80, 32'h80);
      rdc(A_RX, 32'hFF, 32'h55);
      u_rem.send(8'h00, 3'b000, 1'b1);
      chk({31'h0, req_break}, 32'h1);
      bus(1'b0, A_LV, 8'h00, q);
      repeat (q[4:0]) wr(A_ST, 8'hFF);
      repeat (q[4:0]) bus(1'b0, A_RX, 8'h00, q);
      wr(A_ST, 8'hFF);
   endtask

   // Seventeen gapless frames while two stop bits are set; the last finds the queue full.
   task automatic t_over();
      wr(A_FMT, 8'h08);
      wr(A_CTL, 8'h38);
      for (int i = 0; i < 17; i++) u_rem.send(8'(8'h40 + i), 3'b000, 1'b0);
      rdc(A_LV, 32'h1F, 32'h10);
      chk({29'h0, req_rx_full, transfer_engine_rx_req, send_request_out}, 32'h7);
      for (int i = 0; i < 16; i++) rdc(A_RX, 32'hFF, 32'h40 + i);
      wr(A_FMT, 8'h00);
   endtask

   // A withheld permit keeps the line at rest until it is granted.
   task automatic t_modem();
      int z;
      z = 0;
      send_permit_in <= 1'b1;
      wr(A_TX, 8'hC3);
      repeat (64) begin
         @(posedge clk_sys);
         if (serial_out_pin !== 1'b1) z++;
      end
      chk(32'(z), 32'h0);
      send_permit_in <= 1'b0;
      u_rem.recv(r, 8'h00, 16);
      chk({21'h0, r}, 32'h1C3);
      wr(A_CTL, 8'h30);
   endtask

   // Each slower prescale, then the remote clock, stretch the bit time by known factors.
   task automatic t_clk();
      int z;
      logic p;
      for (int s = 1; s < 4; s++) begin
         wr(A_FMT, 8'(s));
         wr(A_TX, 8'h69);
         u_rem.recv(r, 8'h00, 16 << (2 * s));
         chk({21'h0, r}, 32'h169);
         repeat (16 << (2 * s)) @(posedge clk_sys);
      end
      wr(A_FMT, 8'h00);
      ext_run <= 1'b1;
      wr(A_CTL, 8'h22);
      wr(A_TX, 8'h96);
      u_rem.recv(r, 8'h00, 32);
      chk({21'h0, r}, 32'h196);
      repeat (40) @(posedge clk_sys);
      ext_run <= 1'b0;
      wr(A_DIV, 8'h01);
      wr(A_CTL, 8'h31);
      z = 0;
      p = link_clock_pin_out;
      repeat (32) begin
         @(posedge clk_sys);
         if (link_clock_pin_out !== p) z++;
         p = link_clock_pin_out;
      end
      chk(32'(z), 32'h20);
      chk({31'h0, link_clock_pin_oe}, 32'h1);
   endtask

   // Main sequence: six reset cycles, then every scenario.
   initial begin
      rst = 1'b1;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 5'h00;
      avs_writedata = 32'h0;
      send_permit_in = 1'b0;
      ext_run = 1'b0;
      err_total = 0;
      n_checks = 0;
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      t_regs();
      t_tx_fmt();
      t_tx_full();
      t_rx();
      t_over();
      t_modem();
      t_clk();
      summarize();
   end
endmodule // fasp_top_tb_top
`default_nettype wire
